// ==== dv/lrc_host_model.sv ====
// Host controller model speaking the serial engine's byte stream.
`timescale 1ns/1ps
`default_nettype none
module lrc_host_model (
  // Clock
  input wire logic i_mclk,
  // Byte stream
  output logic o_xfer_start,
  output logic o_wr_byte,
  output logic [7:0] o_wr_data,
  output logic o_rd_byte,
  input wire logic [7:0] i_rd_data
);
  initial {o_xfer_start, o_wr_byte, o_wr_data, o_rd_byte} = 11'h14A;
  // Idle data is inverted each slot so a stale byte never looks valid.
  task automatic put(input logic s, input logic w, input logic [7:0] d);
    @(negedge i_mclk);
    o_xfer_start = s;
    o_wr_byte = w;
    o_wr_data = w ? d : ~o_wr_data;
  endtask
  function automatic logic [23:0] lux_centi(input logic [15:0] r);
    return {12'h000, r[11:0]} << r[15:12];
  endfunction
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    put(1'b1, 1'b0, 8'h00);
    put(1'b0, 1'b1, p);
    put(1'b0, 1'b1, v[15:8]);
    put(1'b0, 1'b1, v[7:0]);
    put(1'b0, 1'b0, 8'h00);
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    put(1'b1, 1'b0, 8'h00);
    put(1'b0, 1'b1, p);
    put(1'b1, 1'b0, 8'h00);
    put(1'b0, 1'b0, 8'h00);
    @(negedge i_mclk);
    o_rd_byte = 1'b1;
    @(negedge i_mclk);
    v[15:8] = i_rd_data;
    @(negedge i_mclk);
    o_rd_byte = 1'b0;
    v[7:0] = i_rd_data;
  endtask
endmodule
`default_nettype wire

// ==== dv/lrc_props.sv ====
// Port assertions for the light register block.
`timescale 1ns/1ps
`default_nettype none
module lrc_props #(
  parameter CONV_SHORT_CYC = 20
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Byte stream
  input wire logic i_xfer_start,
  input wire logic i_wr_byte,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_byte,
  input wire logic [7:0] o_rd_data,
  // Front end and flags
  input wire logic [11:0] i_adc_mantissa,
  input wire logic i_adc_overflow,
  input wire logic o_conv_run,
  input wire logic [3:0] o_active_range,
  input wire logic o_integration_period,
  input wire logic i_high_limit_flag,
  input wire logic i_low_limit_flag
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  logic [31:0] cnt;
  logic [3:0] rng_q;
  logic [2:0] wrh;
  wire logic calm = (wrh == 3'h0);
  // A write or a range step restarts the attempt, so the count restarts.
  always_ff @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn) {cnt, rng_q, wrh} <= '0;
    else begin
      rng_q <= o_active_range;
      wrh <= {wrh[1:0], i_wr_byte};
      cnt <= (!o_conv_run || i_wr_byte || o_active_range != rng_q) ?
        32'h0 : cnt + 32'h1;
    end
  AST_RANGE_LEGAL: assert property (o_active_range <= 4'hB)
    else $error("range above max");
  AST_RESET_OUT: assert property ($rose(i_resetn) |-> !o_conv_run &&
    o_active_range == 4'h0 && o_integration_period) else $error("reset out");
  AST_RANGE_STEP: assert property (o_conv_run && calm &&
    $changed(o_active_range) |-> o_active_range ==
    $past(o_active_range) + 4'h1) else $error("range step");
  AST_AT_MAX: assert property (o_conv_run && calm && !i_wr_byte &&
    o_active_range == 4'hB |=> o_active_range == 4'hB) else $error("max");
  AST_RANGE_QUIET: assert property (!o_conv_run && calm &&
    !i_wr_byte |=> $stable(o_active_range)) else $error("idle range");
  AST_PERIOD_QUIET: assert property (calm && !i_wr_byte |=>
    $stable(o_integration_period)) else $error("period moved");
  AST_RD_STANDS: assert property (!i_rd_byte |=> $stable(o_rd_data))
    else $error("read byte moved");
  AST_CONV_MIN: assert property ($fell(o_conv_run) && calm |->
    cnt + 32'd3 >= CONV_SHORT_CYC) else $error("conversion short");
  cover property ($fell(o_conv_run));
  cover property ($rose(o_conv_run));
  cover property (o_conv_run && o_active_range == 4'hB);
endmodule
bind lrc_light_regs lrc_props #(.CONV_SHORT_CYC(CONV_SHORT_CYC)) u_props (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_xfer_start(i_xfer_start),
  .i_wr_byte(i_wr_byte), .i_wr_data(i_wr_data), .i_rd_byte(i_rd_byte),
  .o_rd_data(o_rd_data), .i_adc_mantissa(i_adc_mantissa),
  .i_adc_overflow(i_adc_overflow), .o_conv_run(o_conv_run),
  .o_active_range(o_active_range),
  .o_integration_period(o_integration_period),
  .i_high_limit_flag(i_high_limit_flag), .i_low_limit_flag(i_low_limit_flag));
`default_nettype wire

// ==== dv/tb_lrc_light_regs.sv ====
// Self-checking bench for the light result and configuration registers.
`timescale 1ns/1ps
`default_nettype none
`include "lrc_consts.vh"
module tb_lrc_light_regs;
  logic clk, rstn, ovf, hi, lo;
  logic [11:0] mant;
  logic [3:0] lim;
  logic [31:0] seed, x;
  logic [15:0] got, res, c;
  logic [23:0] lx;
  wire logic xs, wb, rb, run, per;
  wire logic [7:0] wd, rdd;
  wire logic [3:0] rng;
  int bad_count, comparisons;
  lrc_light_regs #(.CONV_SHORT_CYC(20), .CONV_LONG_CYC(40)) DUT (
    .i_mclk(clk), .i_resetn(rstn), .i_xfer_start(xs), .i_wr_byte(wb),
    .i_wr_data(wd), .i_rd_byte(rb), .o_rd_data(rdd), .i_adc_mantissa(mant),
    .i_adc_overflow(ovf), .o_conv_run(run), .o_active_range(rng),
    .o_integration_period(per), .i_high_limit_flag(hi),
    .i_low_limit_flag(lo));
  lrc_host_model host (.i_mclk(clk), .o_xfer_start(xs), .o_wr_byte(wb),
    .o_wr_data(wd), .o_rd_byte(rb), .i_rd_data(rdd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Light stays over range until the chosen range is reached.
  always @(negedge clk) ovf <= (rng < lim);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Exponent the host should see for a config word and a light level.
  function automatic logic [3:0] exp_range(input logic [15:0] v,
    input logic [3:0] l);
    if (v[15:12] != 4'hC) return v[2] ? 4'h0 : v[15:12];
    return (l > 4'hB) ? 4'hB : l;
  endfunction
  task automatic chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic conv(input logic [15:0] v, input logic [3:0] l);
    int n;
    logic [3:0] e;
    x = rnd();
    mant = x[11:0];
    lim = l;
    host.wr(8'h01, v);
    for (n = 0; n < 900 && run !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 900 && run !== 1'b0; n++) @(negedge clk);
    chk("single end", {15'h0, run}, 16'h0);
    e = exp_range(v, l);
    host.rd(8'h00, res);
    chk("result", res, {e, mant});
    host.rd(8'h01, got);
    chk("config", got, v & 16'hF81F | {7'h0, l > 4'hB, 8'h80});
    $display("conversion %h finished", v);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    {seed, rstn, hi, lo, mant, lim} = {32'h00009DB0, 19'h0};
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    host.rd(8'h00, got);
    chk("result reset", got, `LRC_RESULT_RESET);
    host.rd(8'h01, got);
    chk("config reset", got, `LRC_CONFIG_RESET);
    for (int k = 0; k < 4; k++) begin
      x = rnd();
      c = x[15:0];
      c[15:12] = x[19:16] % 4'hD;
      c[10:9] = 2'b00;
      {hi, lo} = x[21:20];
      host.wr(8'h01, c);
      host.rd(8'h01, got);
      chk("config rw", got, c & 16'hFE1F | {9'h0, hi, lo, 5'h0});
      chk("period", {15'h0, per}, {15'h0, c[11]});
    end
    {hi, lo} = 2'b00;
    host.wr(8'h00, 16'hFFFF);
    host.rd(8'h00, got);
    chk("result ro", got, 16'h0000);
    host.rd(8'h05, got);
    chk("unmapped", got, 16'h0000);
    lx = host.lux_centi(16'h3456);
    chk("lux", lx[15:0], 16'h22B0);
    $display("register access test finished");
    for (int k = 0; k < 15; k++) begin
      x = rnd();
      c = {(k < 12) ? k[3:0] : 4'hC, x[0], 2'b01, 4'h0, x[5:1]};
      conv(c, (k < 12) ? 4'h0 : (k == 13) ? 4'h3 : 4'hF);
    end
    host.wr(8'h01, 16'h5A10);
    repeat (12) @(negedge clk);
    conv(16'h5A10, 4'h0);
    host.wr(8'h01, 16'h5A10);
    repeat (12) @(negedge clk);
    host.wr(8'h01, 16'h5810);
    repeat (3) @(negedge clk);
    chk("abort", {15'h0, run}, 16'h0);
    // A new mantissa shows up only if the aborted attempt still ends.
    mant = ~mant;
    repeat (50) @(negedge clk);
    host.rd(8'h00, got);
    chk("result kept", got, res);
    host.wr(8'h01, 16'hC410);
    repeat (100) @(negedge clk);
    chk("continuous", {15'h0, run}, 16'h1);
    host.wr(8'h01, 16'hC610);
    repeat (50) @(negedge clk);
    chk("continuous 11", {15'h0, run}, 16'h1);
    host.wr(8'h01, 16'hC010);
    repeat (3) @(negedge clk);
    chk("shutdown", {15'h0, run}, 16'h0);
    host.rd(8'h01, got);
    chk("ready set", got, 16'hC090);
    host.rd(8'h01, got);
    chk("ready cleared", got, 16'hC010);
    $display("abort and mode test finished");
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== hw/lrc_byte_pack.v ====
// Byte lane: register pointer, high-byte-first word assembly and readout.
`timescale 1ns/1ps
`default_nettype none
module lrc_byte_pack (
  // Clock and reset
  input wire i_mclk,
  input wire i_resetn,
  // Byte stream from the serial engine
  input wire i_xfer_start,
  input wire i_wr_byte,
  input wire [7:0] i_wr_data,
  input wire i_rd_byte,
  output reg [7:0] o_rd_data,
  // Word side
  input wire [15:0] i_rd_word,
  output reg [7:0] o_ptr,
  output reg o_word_wr,
  output reg [15:0] o_word,
  output reg o_rd_fetch
);
  reg [1:0] wr_phase;
  reg rd_phase;
  reg [7:0] hold_hi;
  reg [7:0] hold_lo;

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_phase <= 2'h0;
      rd_phase <= 1'b0;
      hold_hi <= 8'h00;
      hold_lo <= 8'h00;
      o_ptr <= 8'h00;
      o_word_wr <= 1'b0;
      o_word <= 16'h0000;
      o_rd_data <= 8'h00;
      o_rd_fetch <= 1'b0;
    end else begin
      o_word_wr <= 1'b0;
      o_rd_fetch <= 1'b0;
      if (i_xfer_start) begin
        wr_phase <= 2'h0;
        rd_phase <= 1'b0;
      end else if (i_wr_byte) begin
        case (wr_phase)
          2'h0: begin
            o_ptr <= i_wr_data;
            wr_phase <= 2'h1;
          end
          2'h1: begin
            hold_hi <= i_wr_data;
            wr_phase <= 2'h2;
          end
          2'h2: begin
            o_word <= {hold_hi, i_wr_data};
            o_word_wr <= 1'b1;
            wr_phase <= 2'h3;
          end
          default: wr_phase <= 2'h3;
        endcase
      end else if (i_rd_byte) begin
        if (!rd_phase) begin
          o_rd_data <= i_rd_word[15:8];
          hold_lo <= i_rd_word[7:0];
          o_rd_fetch <= 1'b1;
        end else begin
          o_rd_data <= hold_lo;
        end
        rd_phase <= ~rd_phase;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/lrc_consts.vh ====
// Offsets, field positions, reset values and timing for the light registers.
`ifndef LRC_CONSTS_VH
`define LRC_CONSTS_VH

`define LRC_OFF_RESULT 8'h00
`define LRC_OFF_CONFIG 8'h01

`define LRC_RESULT_RESET 16'h0000
`define LRC_CONFIG_RESET 16'hC810
// Host-writable bits of the configuration word (15:9 and 4:0).
`define LRC_CONFIG_RW_MASK 16'hFE1F

`define LRC_EXP_HI 15
`define LRC_EXP_LO 12
`define LRC_MANT_HI 11
`define LRC_MANT_LO 0

`define LRC_CFG_RANGE_HI 15
`define LRC_CFG_RANGE_LO 12
`define LRC_CFG_PERIOD 11
`define LRC_CFG_MODE_HI 10
`define LRC_CFG_MODE_LO 9
`define LRC_CFG_OVF 8
`define LRC_CFG_READY 7
`define LRC_CFG_HIGH 6
`define LRC_CFG_LOW 5
`define LRC_CFG_EXPMASK 2

`define LRC_RANGE_AUTO 4'hC
`define LRC_RANGE_MAX 4'hB
`define LRC_MODE_OFF 2'h0
`define LRC_MODE_SINGLE 2'h1

`define LRC_CLK_PERIOD_NS 4
`define LRC_CONV_SHORT_MS 100
`define LRC_CONV_LONG_MS 800
`define LRC_NS_PER_MS 1000000

`endif

// ==== hw/lrc_light_regs.v ====
// Result and configuration registers with conversion sequencing.
// What this block does
// - Latest completed conversion held in read-only result.
// - Exponent bits 15:12, mantissa bits 11:0.
// - Result exponent and mantissa reset to zero.
// - Mantissa is unsigned straight binary.
// - Exponent 0..11 picks step 0.01 lux times 2^e.
// - Mask plus manual range reads exponent zero.
// - Configuration at offset 01h, resets to C810h.
// - Configuration write aborts running conversion.
// - New settings requesting conversion start one.
// - Bits 15:9, 4:0 writable; 8:5 status flags.
// - Range field uses the exponent encoding.
// - Range code 1100b selects automatic range.
// - Range field powers up as automatic.
// - Result register sits at offset 00h.
// - Mode: shutdown, single-shot self-clearing, continuous.
// - Period bit selects 100 ms or 800 ms.
// - Auto overflow below max raises range, restarts.
// - Words travel high byte first.
`timescale 1ns/1ps
`default_nettype none
`include "lrc_consts.vh"
module lrc_light_regs #(
  parameter CLK_NS = `LRC_CLK_PERIOD_NS,
  parameter CONV_SHORT_CYC =
    `LRC_CONV_SHORT_MS * `LRC_NS_PER_MS / CLK_NS,
  parameter CONV_LONG_CYC =
    `LRC_CONV_LONG_MS * `LRC_NS_PER_MS / CLK_NS
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_resetn,
  // Byte stream from the serial engine
  input wire i_xfer_start,
  input wire i_wr_byte,
  input wire [7:0] i_wr_data,
  input wire i_rd_byte,
  output wire [7:0] o_rd_data,
  // Light front end
  input wire [11:0] i_adc_mantissa,
  input wire i_adc_overflow,
  output reg o_conv_run,
  output reg [3:0] o_active_range,
  output wire o_integration_period,
  // Limit comparator flags
  input wire i_high_limit_flag,
  input wire i_low_limit_flag
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg state;
  reg [27:0] conv_cnt;
  reg [15:0] light_result;
  reg [15:0] cfg_rw;
  reg overflow_flag;
  reg conversion_ready_flag;
  reg high_limit_flag;
  reg low_limit_flag;
  reg ovf_seen;
  reg [15:0] rd_word;

  wire [7:0] ptr;
  wire word_wr;
  wire [15:0] word;
  wire rd_fetch;
  wire cfg_wr;
  wire [3:0] range_select;
  wire [1:0] mode;
  wire exponent_mask_enable;
  wire auto_range;
  wire [27:0] conv_len;
  wire conv_end;
  wire auto_retry;
  wire [15:0] cfg_view;

  lrc_byte_pack u_pack (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_xfer_start(i_xfer_start),
    .i_wr_byte(i_wr_byte),
    .i_wr_data(i_wr_data),
    .i_rd_byte(i_rd_byte),
    .o_rd_data(o_rd_data),
    .i_rd_word(rd_word),
    .o_ptr(ptr),
    .o_word_wr(word_wr),
    .o_word(word),
    .o_rd_fetch(rd_fetch)
  );

  // The live field and the write path must agree on what automatic means.
  function is_auto(input [3:0] code);
    is_auto = (code == `LRC_RANGE_AUTO);
  endfunction

  assign cfg_wr = word_wr && (ptr == `LRC_OFF_CONFIG);
  assign range_select = cfg_rw[`LRC_CFG_RANGE_HI:`LRC_CFG_RANGE_LO];
  assign mode = cfg_rw[`LRC_CFG_MODE_HI:`LRC_CFG_MODE_LO];
  assign exponent_mask_enable = cfg_rw[`LRC_CFG_EXPMASK];
  assign auto_range = is_auto(range_select);
  assign o_integration_period = cfg_rw[`LRC_CFG_PERIOD];
  assign conv_len = o_integration_period ? CONV_LONG_CYC[27:0] :
    CONV_SHORT_CYC[27:0];
  assign conv_end = (state == ST_CONV) && (conv_cnt == conv_len - 28'h1);
  assign auto_retry = (state == ST_CONV) && auto_range &&
    i_adc_overflow && (o_active_range != `LRC_RANGE_MAX);

  assign cfg_view = {cfg_rw[15:9], overflow_flag, conversion_ready_flag,
    high_limit_flag, low_limit_flag, cfg_rw[4:0]};

  // Read word is registered so the byte lane sees a stable value.
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_word <= 16'h0000;
    end else begin
      case (ptr)
        `LRC_OFF_RESULT: begin
          if (exponent_mask_enable && !auto_range) begin
            rd_word <= {4'h0, light_result[`LRC_MANT_HI:`LRC_MANT_LO]};
          end else begin
            rd_word <= light_result;
          end
        end
        `LRC_OFF_CONFIG: rd_word <= cfg_view;
        default: rd_word <= 16'h0000;
      endcase
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_rw <= `LRC_CONFIG_RESET & `LRC_CONFIG_RW_MASK;
      light_result <= `LRC_RESULT_RESET;
      overflow_flag <= 1'b0;
      conversion_ready_flag <= 1'b0;
      high_limit_flag <= 1'b0;
      low_limit_flag <= 1'b0;
      ovf_seen <= 1'b0;
      state <= ST_IDLE;
      conv_cnt <= 28'h0;
      o_conv_run <= 1'b0;
      o_active_range <= 4'h0;
    end else begin
      high_limit_flag <= i_high_limit_flag;
      low_limit_flag <= i_low_limit_flag;
      // Ready clears when the config word is fetched; a completion wins.
      // An attempt cut short by a range step is not a completion.
      if (conv_end && !cfg_wr && !auto_retry) begin
        conversion_ready_flag <= 1'b1;
      end else if (rd_fetch && ptr == `LRC_OFF_CONFIG) begin
        conversion_ready_flag <= 1'b0;
      end
      if (cfg_wr) begin
        cfg_rw <= word & `LRC_CONFIG_RW_MASK;
        conv_cnt <= 28'h0;
        ovf_seen <= 1'b0;
        if (word[`LRC_CFG_MODE_HI:`LRC_CFG_MODE_LO] != `LRC_MODE_OFF) begin
          state <= ST_CONV;
          o_conv_run <= 1'b1;
        end else begin
          state <= ST_IDLE;
          o_conv_run <= 1'b0;
        end
        if (is_auto(word[`LRC_CFG_RANGE_HI:`LRC_CFG_RANGE_LO])) begin
          o_active_range <= 4'h0;
        end else begin
          o_active_range <= word[`LRC_CFG_RANGE_HI:`LRC_CFG_RANGE_LO];
        end
      end else begin
        case (state)
          ST_IDLE: begin
            o_conv_run <= 1'b0;
            conv_cnt <= 28'h0;
          end
          ST_CONV: begin
            if (auto_retry) begin
              o_active_range <= o_active_range + 4'h1;
              conv_cnt <= 28'h0;
            end else if (conv_end) begin
              light_result <= {o_active_range, i_adc_mantissa};
              overflow_flag <= ovf_seen | i_adc_overflow;
              ovf_seen <= 1'b0;
              conv_cnt <= 28'h0;
              if (mode == `LRC_MODE_SINGLE) begin
                cfg_rw[`LRC_CFG_MODE_HI:`LRC_CFG_MODE_LO] <= `LRC_MODE_OFF;
                state <= ST_IDLE;
                o_conv_run <= 1'b0;
              end
            end else begin
              conv_cnt <= conv_cnt + 28'h1;
              if (i_adc_overflow) begin
                ovf_seen <= 1'b1;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire
